/* shared/asrc_pkg.sv */
// Constants, fields and carriers for the converter select and result control block
// Operation
// - Mux on, converter off: channel drives comparator minus
// - Otherwise comparator minus comes from dedicated pins
// - Pin select code picks plus/minus pin pair
// - Mux mode: code picks plus pin, channel minus
// - Hysteresis on when set; level picks 20/50mV
// - Channel field selects any of eleven inputs
// - Differential gain 1/8/20/32x; single-ended bypasses
// - Reference field picks supply, pin or internal
// - Channel code all ones selects temperature sensor
// - Selections reach converter only while enabled
// - Result right-aligned, left-aligned when bit set
// - Low read locks result; high read unlocks
// - Completion while locked discards new result
// - Done flag still set when result discarded
// - Completion writes result and sets flag together
// - Start bit stays set until conversion completes or enable is cleared
package asrc_pkg;
   localparam int ASRC_ADDR_W = 10;
   localparam int ASRC_DATA_W = 32;
   localparam int ASRC_RES_W = 10;
   localparam int ASRC_CH_W = 6;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CONV_CTRL_B = 8'h03;
   localparam logic [7:0] IDX_RESULT_LOW = 8'h04;
   localparam logic [7:0] IDX_RESULT_HIGH = 8'h05;
   localparam logic [7:0] IDX_CONV_CTRL_A = 8'h06;
   localparam logic [7:0] IDX_CONV_SEL = 8'h07;
   localparam logic [7:0] IDX_CMP_CTRL_B = 8'h09;
   // Field positions
   localparam int CA_ENABLE = 7;
   localparam int CA_START = 6;
   localparam int CA_DONE = 4;
   localparam int CS_LEFT = 6;
   localparam int CS_REF_LO = 8;
   localparam int CB_GAIN = 7;
   localparam int CB_MUX_EN = 6;
   localparam int CM_HYST_SEL = 7;
   localparam int CM_HYST_LEV = 6;
   localparam int CM_PIN_LO = 0;
   // Reset and fixed values
   localparam logic [5:0] ASRC_CHANNEL_RST = 6'h00;
   localparam logic [2:0] ASRC_REF_RST = 3'h0;
   localparam logic [2:0] ASRC_PIN_SEL_RST = 3'h0;
   localparam logic [9:0] ASRC_RESULT_RST = 10'h000;
   localparam logic [2:0] ASRC_CMP_FIXED = 3'h0;
   localparam logic [7:0] ASRC_BYTE_ZERO = 8'h00;
   localparam logic [23:0] ASRC_PAD = 24'h000000;
   localparam logic [5:0] ASRC_LEFT_PAD = 6'h00;
   // Channel codes
   localparam logic [5:0] ASRC_CH_LAST_PIN = 6'h0A;
   localparam logic [5:0] ASRC_CH_TEMP = 6'h3F;
   // Comparator pin identifiers
   localparam logic [1:0] ASRC_PIN0 = 2'h0;
   localparam logic [1:0] ASRC_PIN1 = 2'h1;
   localparam logic [1:0] ASRC_PIN2 = 2'h2;
   // Comparator pin select codes
   localparam logic [2:0] SEL_P0N1 = 3'h0;
   localparam logic [2:0] SEL_P0N2 = 3'h1;
   localparam logic [2:0] SEL_P1N0 = 3'h2;
   localparam logic [2:0] SEL_P1N2 = 3'h3;
   localparam logic [2:0] SEL_P2N0 = 3'h4;
   localparam logic [1:0] SEL_MUX_P1 = 2'h1;

   typedef enum logic [1:0] {
      GAIN_1X = 2'h0,
      GAIN_8X = 2'h1,
      GAIN_20X = 2'h2,
      GAIN_32X = 2'h3
   } asrc_gain_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BUSY = 2'b10
   } asrc_state_t;

   typedef struct packed {
      logic [1:0] pos_pin;
      logic neg_from_mux;
      logic [1:0] neg_pin;
      logic [5:0] neg_channel;
      logic hyst_on;
      logic hyst_large;
   } asrc_cmp_route_t;

   typedef struct packed {
      logic enable;
      logic [5:0] channel;
      logic [2:0] reference;
      logic differential;
      logic temp_sensor;
      asrc_gain_t gain;
   } asrc_conv_setup_t;
endpackage

/* rtl/asrc_route.sv */
// Comparator input routing and converter channel decode
module asrc_route (
   input wire logic mux_enable, // Comparator mux enable field
   input wire logic conv_enable, // Converter enable field
   input wire logic [5:0] channel, // Channel select field
   input wire logic [2:0] pin_select, // Comparator pin select field
   input wire logic [2:0] reference, // Reference select field
   input wire logic gain_select, // Gain select field
   input wire logic hyst_sel, // Hysteresis select field
   input wire logic hyst_lev, // Hysteresis level field
   output asrc_pkg::asrc_cmp_route_t route, // Decoded comparator route
   output asrc_pkg::asrc_conv_setup_t setup // Decoded converter setup
);
   import asrc_pkg::*;

   wire mux_active = mux_enable & ~conv_enable;
   wire [1:0] pos_direct;
   wire [1:0] neg_direct;
   wire [1:0] pos_mux;
   wire is_temp;
   wire is_single;
   wire is_diff;
   wire [1:0] diff_gain;

   // Direct pin pairs; the three top codes share one pair
   assign pos_direct = (pin_select == SEL_P0N1 || pin_select == SEL_P0N2) ? ASRC_PIN0 :
                       (pin_select == SEL_P1N0 || pin_select == SEL_P1N2) ? ASRC_PIN1 :
                       ASRC_PIN2;
   assign neg_direct = (pin_select == SEL_P0N2 || pin_select == SEL_P1N2) ? ASRC_PIN2 :
                       (pin_select == SEL_P1N0 || pin_select == SEL_P2N0) ? ASRC_PIN0 :
                       ASRC_PIN1;
   assign pos_mux = (pin_select[2]) ? ASRC_PIN2 :
                    (pin_select[2:1] == SEL_MUX_P1) ? ASRC_PIN1 :
                    ASRC_PIN0;

   assign route = '{
      pos_pin: mux_active ? pos_mux : pos_direct,
      neg_from_mux: mux_active,
      neg_pin: neg_direct,
      neg_channel: channel,
      hyst_on: hyst_sel,
      hyst_large: hyst_sel & hyst_lev
   };

   assign is_temp = (channel == ASRC_CH_TEMP);
   assign is_single = (channel <= ASRC_CH_LAST_PIN);
   assign is_diff = ~is_single & ~is_temp;
   // Low channel bit with the gain bit picks one of four gains
   assign diff_gain = {gain_select, channel[0]};

   assign setup = '{
      enable: conv_enable,
      channel: channel,
      reference: reference,
      differential: is_diff,
      temp_sensor: is_temp,
      gain: is_diff ? asrc_gain_t'(diff_gain) : GAIN_1X
   };
endmodule

/* rtl/asrc_ctrl.sv */
// APB register file, conversion sequencing and result lock
//
// Added by the designer: the APB register port.
module asrc_ctrl #(
   parameter int RES_W = asrc_pkg::ASRC_RES_W
) (
   input wire logic pclk, // Bus clock
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [asrc_pkg::ASRC_ADDR_W-1:0] paddr, // APB byte address
   input wire logic [asrc_pkg::ASRC_DATA_W-1:0] pwdata, // APB write data
   output logic pready, // APB ready
   output logic [asrc_pkg::ASRC_DATA_W-1:0] prdata, // APB read data
   output logic pslverr, // APB error
   input wire logic conv_done, // Core conversion complete pulse
   input wire logic [RES_W-1:0] conv_result, // Core result word
   output logic conv_start, // Start pulse to the core
   output asrc_pkg::asrc_conv_setup_t conv_setup, // Applied converter setup
   output asrc_pkg::asrc_cmp_route_t cmp_route, // Comparator input routing
   output logic done_flag // Conversion complete condition
);
   import asrc_pkg::*;

   if (RES_W != ASRC_RES_W) begin : g_chk
      $error("asrc_ctrl: result formatting serves only a 10-bit result");
   end

   // Bus handshake: one wait cycle so every output leaves a flop
   logic pready_reg;
   logic [ASRC_DATA_W-1:0] prdata_reg;
   logic pslverr_reg;

   wire access = psel & penable;
   wire capture = access & ~pready_reg;
   wire complete = access & pready_reg;
   wire aligned = (paddr[1:0] == 2'h0);
   wire [7:0] widx = paddr[ASRC_ADDR_W-1:2];

   wire hit_ctrl_a = aligned & (widx == IDX_CONV_CTRL_A);
   wire hit_ctrl_b = aligned & (widx == IDX_CONV_CTRL_B);
   wire hit_sel = aligned & (widx == IDX_CONV_SEL);
   wire hit_cmp_b = aligned & (widx == IDX_CMP_CTRL_B);
   wire hit_low = aligned & (widx == IDX_RESULT_LOW);
   wire hit_high = aligned & (widx == IDX_RESULT_HIGH);
   wire hit_any = hit_ctrl_a | hit_ctrl_b | hit_sel | hit_cmp_b | hit_low | hit_high;

   // Writes land only at the edge where the master sees pready
   wire wr = complete & pwrite;
   wire wr_ctrl_a = wr & hit_ctrl_a;
   wire wr_ctrl_b = wr & hit_ctrl_b;
   wire wr_sel = wr & hit_sel;
   wire wr_cmp_b = wr & hit_cmp_b;

   // Read side effects act at the capture edge, together with the data
   wire rd_cap = capture & ~pwrite;
   wire rd_low = rd_cap & hit_low;
   wire rd_high = rd_cap & hit_high;

   // Control fields
   logic conv_en_reg;
   logic conv_en_next;
   logic done_flag_reg;
   logic done_flag_next;
   logic [5:0] channel_reg;
   logic left_reg;
   logic [2:0] ref_reg;
   logic gain_sel_reg;
   logic mux_en_reg;
   logic hyst_sel_reg;
   logic hyst_lev_reg;
   logic [2:0] pin_sel_reg;

   // Conversion state and result
   asrc_state_t state_reg;
   asrc_state_t state_next;
   logic conv_start_reg;
   logic [RES_W-1:0] result_reg;
   logic lock_reg;
   logic lock_next;
   asrc_conv_setup_t setup_reg;
   asrc_cmp_route_t route_reg;

   asrc_cmp_route_t route_dec;
   asrc_conv_setup_t setup_dec;

   // The enable written at this edge counts, so a start that also sets the
   // enable loads a setup that already shows the converter enabled
   asrc_route u_route (
      .mux_enable(mux_en_reg),
      .conv_enable(conv_en_next),
      .channel(channel_reg),
      .pin_select(pin_sel_reg),
      .reference(ref_reg),
      .gain_select(gain_sel_reg),
      .hyst_sel(hyst_sel_reg),
      .hyst_lev(hyst_lev_reg),
      .route(route_dec),
      .setup(setup_dec)
   );

   // Enable follows the written value; clearing it aborts a conversion
   assign conv_en_next = wr_ctrl_a ? pwdata[CA_ENABLE] : conv_en_reg;

   wire is_busy = (state_reg == ST_BUSY);
   wire start_req = wr_ctrl_a & pwdata[CA_START] & conv_en_next;
   wire done_evt = conv_done & is_busy & conv_en_reg;

   // Flag: completion sets, writing one clears, set wins over clear
   assign done_flag_next = (done_flag_reg & ~(wr_ctrl_a & pwdata[CA_DONE])) | done_evt;

   // Lock: low-byte read sets, high-byte read clears
   assign lock_next = rd_low ? 1'b1 : (rd_high ? 1'b0 : lock_reg);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (start_req) begin
               state_next = ST_BUSY;
            end
         end
         ST_BUSY: begin
            if (done_evt || !conv_en_next) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         conv_start_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         conv_start_reg <= (state_reg == ST_IDLE) & start_req;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_en_reg <= 1'b0;
         done_flag_reg <= 1'b0;
      end else begin
         conv_en_reg <= conv_en_next;
         done_flag_reg <= done_flag_next;
      end
   end

   // Result update is skipped while locked; the flag is not. A low-byte
   // read at the completion edge already blocks, so the pair stays coherent
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_reg <= ASRC_RESULT_RST;
      end else if (done_evt && !lock_next) begin
         result_reg <= conv_result;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_reg <= 1'b0;
      end else begin
         lock_reg <= lock_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_reg <= ASRC_CHANNEL_RST;
         left_reg <= 1'b0;
         ref_reg <= ASRC_REF_RST;
      end else if (wr_sel) begin
         channel_reg <= pwdata[ASRC_CH_W-1:0];
         left_reg <= pwdata[CS_LEFT];
         ref_reg <= pwdata[CS_REF_LO +: 3];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gain_sel_reg <= 1'b0;
         mux_en_reg <= 1'b0;
      end else if (wr_ctrl_b) begin
         gain_sel_reg <= pwdata[CB_GAIN];
         mux_en_reg <= pwdata[CB_MUX_EN];
      end
   end

   // Bits 5:3 are not stored, so writes to them have no effect
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hyst_sel_reg <= 1'b0;
         hyst_lev_reg <= 1'b0;
         pin_sel_reg <= ASRC_PIN_SEL_RST;
      end else if (wr_cmp_b) begin
         hyst_sel_reg <= pwdata[CM_HYST_SEL];
         hyst_lev_reg <= pwdata[CM_HYST_LEV];
         pin_sel_reg <= pwdata[CM_PIN_LO +: 3];
      end
   end

   // Setup tracks the fields only while enabled and idle, so a running
   // conversion keeps its channel and reference to the end
   wire setup_load = conv_en_next & (state_reg == ST_IDLE);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         setup_reg <= '0;
      end else if (setup_load) begin
         setup_reg <= setup_dec;
      end else if (!conv_en_next) begin
         setup_reg.enable <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         route_reg <= '0;
      end else begin
         route_reg <= route_dec;
      end
   end

   // Result byte formatting follows the alignment bit at read time
   wire [7:0] res_low_right = result_reg[7:0];
   wire [7:0] res_high_right = {ASRC_LEFT_PAD, result_reg[9:8]};
   wire [7:0] res_low_left = {result_reg[1:0], ASRC_LEFT_PAD};
   wire [7:0] res_high_left = result_reg[9:2];
   wire [7:0] res_low = left_reg ? res_low_left : res_low_right;
   wire [7:0] res_high = left_reg ? res_high_left : res_high_right;

   wire [7:0] rd_ctrl_a;
   wire [7:0] rd_ctrl_b;
   wire [7:0] rd_cmp_b;
   wire [7:0] rd_byte;
   wire [ASRC_DATA_W-1:0] rd_sel;
   wire [ASRC_DATA_W-1:0] rd_word;

   assign rd_ctrl_a = {conv_en_reg, is_busy, 1'b0, done_flag_reg, 4'h0};
   assign rd_ctrl_b = {gain_sel_reg, mux_en_reg, 6'h00};
   assign rd_cmp_b = {hyst_sel_reg, hyst_lev_reg, ASRC_CMP_FIXED, pin_sel_reg};
   assign rd_sel = {ASRC_PAD[20:0], ref_reg, 1'b0, left_reg, channel_reg};

   assign rd_byte = hit_ctrl_a ? rd_ctrl_a :
                    hit_ctrl_b ? rd_ctrl_b :
                    hit_cmp_b ? rd_cmp_b :
                    hit_low ? res_low :
                    hit_high ? res_high :
                    ASRC_BYTE_ZERO;
   assign rd_word = hit_sel ? rd_sel : {ASRC_PAD, rd_byte};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= capture;
         pslverr_reg <= capture & ~hit_any;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= '0;
      end else if (rd_cap) begin
         prdata_reg <= rd_word;
      end else if (complete) begin
         prdata_reg <= '0;
      end
   end

   assign pready = pready_reg;
   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;
   assign conv_start = conv_start_reg;
   assign conv_setup = setup_reg;
   assign cmp_route = route_reg;
   assign done_flag = done_flag_reg;
endmodule

/* verif/asrc_ctrl_monitor.sv */
// Port-level checks for the converter control block
module asrc_ctrl_monitor #(
   parameter int RES_W = asrc_pkg::ASRC_RES_W
) (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset
   input wire logic psel, // Select
   input wire logic penable, // Enable
   input wire logic pwrite, // Direction
   input wire logic [asrc_pkg::ASRC_ADDR_W-1:0] paddr, // Address
   input wire logic [asrc_pkg::ASRC_DATA_W-1:0] pwdata, // Write data
   input wire logic pready, // Ready
   input wire logic [asrc_pkg::ASRC_DATA_W-1:0] prdata, // Read data
   input wire logic pslverr, // Error
   input wire logic conv_done, // Core done
   input wire logic [RES_W-1:0] conv_result, // Core result
   input wire logic conv_start, // Start
   input asrc_pkg::asrc_conv_setup_t conv_setup, // Setup
   input asrc_pkg::asrc_cmp_route_t cmp_route, // Route
   input wire logic done_flag // Done flag
);
   timeunit 1ns;
   timeprecision 1ps;
   import asrc_pkg::*;
   logic busy_reg;
   // Shadow of a conversion in flight; cleared by completion or abort
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) busy_reg <= 1'b0;
      else if (conv_start) busy_reg <= 1'b1;
      else if (conv_done || !conv_setup.enable) busy_reg <= 1'b0;
   end
   default clocking dck @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_one_wait;
      psel && !penable ##1 psel && penable |-> !pready ##1 pready;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("bad wait count");
   property p_err_data;
      pslverr |-> pready && prdata == '0;
   endproperty
   a_err_data: assert property (p_err_data) else $error("error with data");
   property p_start_en;
      conv_start |-> conv_setup.enable ##1 !conv_start;
   endproperty
   a_start_en: assert property (p_start_en) else $error("bad start");
   property p_frozen;
      busy_reg && !conv_done && conv_setup.enable
         |=> $stable(conv_setup.channel) && $stable(conv_setup.reference);
   endproperty
   a_frozen: assert property (p_frozen) else $error("setup moved");
   property p_done_flag;
      busy_reg && conv_done && conv_setup.enable |=> done_flag;
   endproperty
   a_done_flag: assert property (p_done_flag) else $error("no flag");
   property p_flag_cause;
      $rose(done_flag) |-> $past(conv_done);
   endproperty
   a_flag_cause: assert property (p_flag_cause) else $error("stray flag");
   property p_hyst;
      cmp_route.hyst_large |-> cmp_route.hyst_on;
   endproperty
   a_hyst: assert property (p_hyst) else $error("level without hyst");
   property p_pins;
      $past(presetn, 2) && !cmp_route.neg_from_mux |-> cmp_route.pos_pin != cmp_route.neg_pin;
   endproperty
   a_pins: assert property (p_pins) else $error("same pin twice");
   property p_temp;
      conv_setup.channel == ASRC_CH_TEMP |-> conv_setup.temp_sensor && !conv_setup.differential;
   endproperty
   a_temp: assert property (p_temp) else $error("temp decode");
   property p_single;
      conv_setup.channel <= ASRC_CH_LAST_PIN |-> !conv_setup.differential;
   endproperty
   a_single: assert property (p_single) else $error("single decode");
   c_start: cover property (conv_start);
   c_done: cover property (busy_reg && conv_done);
   c_mux: cover property (cmp_route.neg_from_mux);
endmodule

bind asrc_ctrl asrc_ctrl_monitor #(.RES_W(RES_W)) i_asrc_ctrl_monitor (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .conv_done(conv_done), .conv_result(conv_result), .conv_start(conv_start),
   .conv_setup(conv_setup), .cmp_route(cmp_route), .done_flag(done_flag)
);

/* verif/asrc_core_model.sv */
// Behavioural converter core answering start pulses
module asrc_core_model (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset
   input wire logic conv_start, // Start pulse
   input wire logic [7:0] latency, // Completion comes this many cycles plus two after start
   input wire logic [9:0] value, // Result to return
   output logic conv_done, // Done pulse
   output logic [9:0] conv_result // Result word
);
   timeunit 1ns;
   timeprecision 1ps;
   logic busy_reg;
   logic [7:0] cnt_reg;
   wire finish = busy_reg && !conv_start && cnt_reg == 8'h00;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_reg <= 1'b0;
         cnt_reg <= 8'h00;
         conv_done <= 1'b0;
         conv_result <= 10'h000;
      end else begin
         conv_done <= finish;
         // Result lines carry nothing useful between completions
         conv_result <= finish ? value : ~conv_result;
         if (conv_start) begin
            busy_reg <= 1'b1;
            cnt_reg <= latency;
         end else if (finish) begin
            busy_reg <= 1'b0;
         end else if (busy_reg) begin
            cnt_reg <= cnt_reg - 8'h01;
         end
      end
   end
endmodule

/* verif/test_adc_select_result_ctrl.sv */
// Self-checking bench for the converter control block
module test_adc_select_result_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import asrc_pkg::*;
   // Route {pos,mux,neg,hyst}, setup {diff,temp,gain}
   typedef struct packed {
      logic [7:0] cb;
      logic [7:0] gb;
      logic [10:0] sel;
      logic en;
      logic [6:0] rt;
      logic [3:0] st;
   } asrc_row_t;
   localparam asrc_row_t ROWS [15] = '{
      '{8'h00, 8'h00, 11'h000, 1'b0, 7'h04, 4'h0},
      '{8'h01, 8'h00, 11'h000, 1'b0, 7'h08, 4'h0},
      '{8'h02, 8'h00, 11'h000, 1'b0, 7'h20, 4'h0},
      '{8'h03, 8'h00, 11'h000, 1'b0, 7'h28, 4'h0},
      '{8'h84, 8'h00, 11'h000, 1'b0, 7'h42, 4'h0},
      '{8'hC5, 8'h00, 11'h000, 1'b0, 7'h47, 4'h0},
      '{8'h46, 8'h00, 11'h000, 1'b0, 7'h44, 4'h0},
      '{8'h00, 8'h40, 11'h000, 1'b1, 7'h04, 4'h0},
      '{8'h00, 8'h40, 11'h000, 1'b0, 7'h10, 4'h0},
      '{8'h03, 8'h40, 11'h005, 1'b0, 7'h30, 4'h0},
      '{8'h06, 8'h40, 11'h00A, 1'b0, 7'h50, 4'h0},
      '{8'h00, 8'h00, 11'h13F, 1'b1, 7'h04, 4'h4},
      '{8'h00, 8'h80, 11'h210, 1'b1, 7'h04, 4'hA},
      '{8'h00, 8'h00, 11'h311, 1'b1, 7'h04, 4'h9},
      '{8'h00, 8'h80, 11'h413, 1'b1, 7'h04, 4'hB}
   };
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h0;
   logic [7:0] lat = 8'h02;
   logic [9:0] val = 10'h000;
   logic pready, pslverr, conv_done, conv_start, done_flag, e;
   logic [31:0] prdata, q;
   logic [9:0] conv_result;
   logic [6:0] gr;
   asrc_conv_setup_t conv_setup;
   asrc_cmp_route_t cmp_route;
   asrc_row_t r;
   int failures = 0;
   int num_checks = 0;
   always #20 pclk = ~pclk;
   asrc_ctrl #(.RES_W(10)) i_asrc_ctrl (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .conv_done(conv_done), .conv_result(conv_result), .conv_start(conv_start),
      .conv_setup(conv_setup), .cmp_route(cmp_route), .done_flag(done_flag)
   );
   asrc_core_model i_asrc_core_model (
      .pclk(pclk), .presetn(presetn), .conv_start(conv_start), .latency(lat),
      .value(val), .conv_done(conv_done), .conv_result(conv_result)
   );
   task automatic conclude;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // Wait for the answer; only the watchdog ends a hang
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      // One wait state: ready at the second access edge
      chk(32'(n), 32'h2);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [9:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(q, x);
   endtask
   task automatic wait_done;
      int n;
      for (n = 0; n < 300 && done_flag !== 1'b1; n++) @(posedge pclk);
      chk(32'(done_flag), 32'h1);
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      chk(32'(cmp_route), 32'h0);
      chk(32'(conv_setup), 32'h0);
      chk(32'(done_flag), 32'h0);
      presetn <= 1'b1;
      rd(10'h024, 32'h0);
      rd(10'h018, 32'h0);
      $display("test reset finished");
      foreach (ROWS[k]) begin
         r = ROWS[k];
         wr(10'h024, 32'(r.cb));
         wr(10'h00C, 32'(r.gb));
         wr(10'h01C, 32'(r.sel));
         wr(10'h018, {24'h0, r.en, 7'h00});
         repeat (2) @(posedge pclk);
         gr = {cmp_route.pos_pin, cmp_route.neg_from_mux,
            cmp_route.neg_from_mux ? 2'b00 : cmp_route.neg_pin,
            cmp_route.hyst_on, cmp_route.hyst_large};
         chk(32'(gr), 32'(r.rt));
         if (r.rt[4]) chk(32'(cmp_route.neg_channel), 32'(r.sel[5:0]));
         if (r.en) chk(32'(conv_setup), 32'({1'b1, r.sel[5:0], r.sel[10:8], r.st}));
         else chk(32'(conv_setup.enable), 32'h0);
      end
      $display("test table finished");
      wr(10'h024, 32'hFF);
      rd(10'h024, 32'hC7);
      apb(1'b0, 10'h3FC, 32'h0);
      chk(32'(e), 32'h1);
      chk(q, 32'h0);
      $display("test access finished");
      lat <= 8'd40;
      val <= 10'h2A5;
      wr(10'h01C, 32'h0);
      wr(10'h018, 32'hC0);
      rd(10'h018, 32'hC0);
      wr(10'h01C, 32'h305);
      rd(10'h01C, 32'h305);
      chk(32'(conv_setup), 32'h2000);
      wait_done();
      rd(10'h018, 32'h90);
      rd(10'h010, 32'hA5);
      rd(10'h014, 32'h02);
      wr(10'h01C, 32'h40);
      rd(10'h010, 32'h40);
      rd(10'h014, 32'hA9);
      $display("test align finished");
      wr(10'h01C, 32'h0);
      rd(10'h010, 32'hA5);
      wr(10'h018, 32'h90);
      rd(10'h018, 32'h80);
      lat <= 8'd2;
      val <= 10'h155;
      wr(10'h018, 32'hC0);
      wait_done();
      rd(10'h014, 32'h02);
      rd(10'h010, 32'hA5);
      rd(10'h014, 32'h02);
      // Disable, then enable and start in one write
      wr(10'h018, 32'h10);
      wr(10'h018, 32'hC0);
      wait_done();
      rd(10'h010, 32'h55);
      rd(10'h014, 32'h01);
      wr(10'h018, 32'h00);
      $display("test lock finished");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(32'(cmp_route), 32'h0);
      chk(32'(done_flag), 32'h0);
      chk(32'(conv_setup), 32'h0);
      presetn <= 1'b1;
      rd(10'h024, 32'h0);
      rd(10'h018, 32'h0);
      $display("test midreset finished");
      conclude();
   end
   initial begin
      #200000;
      failures++;
      conclude();
   end
endmodule
